/* flash_poll_pkg.sv */
// Shared constants for the flash status-polling host: timing, status bit
// positions, register map and state encodings.
// Assumes a single 125 MHz system clock and an asynchronous parallel flash.
package flash_poll_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int T_ACC_NS = 90;
  localparam int T_DF_NS = 20;
  localparam int T_WP_NS = 50;
  // Least times round up to whole cycles
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int DF_CYC = (T_DF_NS * CLK_MHZ + 999) / 1000;
  localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
  // Three synchroniser stages plus the agreement filter
  localparam int SYNC_LAT = 4;
  localparam int CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions on the flash data bus
  localparam int POLL_POS = 7;
  localparam int TOG1_POS = 6;
  localparam int TMO_POS = 5;
  localparam int ETMR_POS = 3;
  localparam int TOG2_POS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;

  localparam int CTRL_START = 0;
  localparam int CTRL_SEL2 = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_RSTCMD = 3;

  localparam int ST_BUSY = 0;
  localparam int ST_RDY = 1;
  localparam int ST_OUT_LO = 2;
  localparam int ST_ERASE_ACT = 4;
  localparam int ST_SECT_SEL = 5;
  localparam int ST_ETMR = 6;
  localparam int ST_POLL = 7;
  localparam int ST_TMO = 8;

  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_LEFT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Encodings
  typedef enum logic [1:0] {
    OUT_NONE = 2'h0,
    OUT_DONE = 2'h1,
    OUT_FAIL = 2'h2,
    OUT_LEFT = 2'h3
  } outcome_t;

  typedef enum logic [3:0] {
    P_IDLE = 4'h0,
    P_RD1 = 4'h1,
    P_RD2 = 4'h3,
    P_EVAL = 4'h2,
    P_RD3 = 4'h6,
    P_RD4 = 4'h7,
    P_EVAL2 = 4'h5,
    P_ARRAY = 4'h4,
    P_RSTCMD = 4'hc
  } poll_state_t;

  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_ACT = 2'h1,
    C_REC = 2'h3
  } cyc_state_t;

endpackage

/* flash_cycle.sv */
// One read or write cycle on the flash pins, with synchronised pin inputs.
// Assumes the flash answers within the access time and releases the bus
// within the float time after chip and output enable rise.
`timescale 1ns/100ps
module flash_cycle
  import flash_poll_pkg::*;
#(
  parameter int AW = 20,
  parameter int DW = 8
)
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic rd_go_in,
  input wire logic wr_go_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [DW-1:0] dq_in,
  input wire logic ready_busy_n_in,
  output logic [AW-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic [DW-1:0] dq_out,
  output logic dq_oe_out,
  output logic [DW-1:0] rdata_out,
  output logic ready_out,
  output logic done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [DW:0] pin_raw;
  logic [DW:0] s1_reg;
  logic [DW:0] s2_reg;
  logic [DW:0] s3_reg;
  logic [DW:0] filt_reg;

  assign pin_raw = {ready_busy_n_in, dq_in};

  genvar gi;
  generate
    for (gi = 0; gi <= DW; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys_in)
      begin
        if (!rstn_in)
        begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          filt_reg[gi] <= 1'b1;
        end
        else
        begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            filt_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
      ready_out <= 1'b1;
    else
      ready_out <= filt_reg[DW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  cyc_state_t cst_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic is_rd_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      cst_reg <= C_IDLE;
      cnt_reg <= '0;
      is_rd_reg <= 1'b0;
      flash_addr_out <= '0;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      dq_out <= '0;
      dq_oe_out <= 1'b0;
      rdata_out <= '0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      case (cst_reg)
        C_IDLE:
        begin
          if (rd_go_in)
          begin
            // Sampling waits out the synchroniser so the captured byte is settled
            cst_reg <= C_ACT;
            is_rd_reg <= 1'b1;
            cnt_reg <= CNT_W'(ACC_CYC + SYNC_LAT - 1);
            flash_addr_out <= addr_in;
            flash_ce_n_out <= 1'b0;
            flash_oe_n_out <= 1'b0;
          end
          else if (wr_go_in)
          begin
            cst_reg <= C_ACT;
            is_rd_reg <= 1'b0;
            cnt_reg <= CNT_W'(WP_CYC - 1);
            flash_addr_out <= addr_in;
            dq_out <= wdata_in;
            dq_oe_out <= 1'b1;
            flash_ce_n_out <= 1'b0;
            flash_we_n_out <= 1'b0;
          end
        end
        C_ACT:
        begin
          if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
          else
          begin
            cst_reg <= C_REC;
            cnt_reg <= CNT_W'(DF_CYC - 1);
            flash_ce_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            flash_we_n_out <= 1'b1;
            if (is_rd_reg)
              rdata_out <= filt_reg[DW-1:0];
          end
        end
        C_REC:
        begin
          // Gap lets the flash float its outputs before the next cycle
          if (cnt_reg != '0)
            cnt_reg <= cnt_reg - 1'b1;
          else
          begin
            cst_reg <= C_IDLE;
            dq_oe_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        default:
          cst_reg <= C_IDLE;
      endcase
    end
  end

endmodule

/* flash_poll_host.sv */
// Host that runs the toggle-bit status check on a parallel flash, with
// a small register file and an interrupt for the outcome.
// Assumes a busy flash at start and no mid-check writes but to irq registers.
`timescale 1ns/100ps

module flash_poll_host
  import flash_poll_pkg::*;
#(
  parameter int AW = 20,
  parameter logic [7:0] RESET_CMD_DATA = 8'hf0
)
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  input wire logic [7:0] dq_in,
  input wire logic ready_busy_n_in,
  output logic [AW-1:0] flash_addr_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  output logic [7:0] dq_out,
  output logic dq_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle engine
  logic rd_go_reg;
  logic wr_go_reg;
  logic [AW-1:0] addr_reg;
  logic [7:0] cyc_rdata;
  logic cyc_done;
  logic ready_sync;
  flash_cycle #(.AW(AW), .DW(8)) u_cycle (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .rd_go_in(rd_go_reg), .wr_go_in(wr_go_reg),
    .addr_in(addr_reg), .wdata_in(RESET_CMD_DATA),
    .dq_in(dq_in), .ready_busy_n_in(ready_busy_n_in),
    .flash_addr_out(flash_addr_out), .flash_ce_n_out(flash_ce_n_out),
    .flash_oe_n_out(flash_oe_n_out), .flash_we_n_out(flash_we_n_out),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out),
    .rdata_out(cyc_rdata), .ready_out(ready_sync),
    .done_out(cyc_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic sel2_reg;
  logic cont_reg;
  logic start_req;
  logic rstcmd_req;
  logic wr_ctrl;
  assign wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
  assign start_req = wr_ctrl && reg_wdata_in[CTRL_START];
  assign rstcmd_req = wr_ctrl && reg_wdata_in[CTRL_RSTCMD];
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      sel2_reg <= 1'b0;
      cont_reg <= 1'b0;
      addr_reg <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        sel2_reg <= reg_wdata_in[CTRL_SEL2];
        cont_reg <= reg_wdata_in[CTRL_CONT];
      end
      if (reg_wr_in && (reg_addr_in == REG_ADDR))
        addr_reg <= reg_wdata_in[AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Toggle-bit check sequencer
  poll_state_t state_reg;
  logic [7:0] samp1_reg;
  logic [7:0] samp2_reg;
  logic [7:0] array_reg;
  logic erase_act_reg;
  logic sect_sel_reg;
  logic fail_pend_reg;
  outcome_t outcome_reg;
  logic ev_done_reg;
  logic ev_fail_reg;
  logic ev_left_reg;
  logic tog_a;
  logic tog_b;
  logic toggled;

  // Erase toggle bit is meaningful only at an address in an erasing sector
  assign tog_a = sel2_reg ? samp1_reg[TOG2_POS] : samp1_reg[TOG1_POS];
  assign tog_b = sel2_reg ? samp2_reg[TOG2_POS] : samp2_reg[TOG1_POS];
  assign toggled = tog_a ^ tog_b;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      state_reg <= P_IDLE;
      rd_go_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      samp1_reg <= '0;
      samp2_reg <= '0;
      array_reg <= '0;
      erase_act_reg <= 1'b0;
      sect_sel_reg <= 1'b0;
      fail_pend_reg <= 1'b0;
      outcome_reg <= OUT_NONE;
      ev_done_reg <= 1'b0;
      ev_fail_reg <= 1'b0;
      ev_left_reg <= 1'b0;
    end
    else
    begin
      rd_go_reg <= 1'b0;
      wr_go_reg <= 1'b0;
      ev_done_reg <= 1'b0;
      ev_fail_reg <= 1'b0;
      ev_left_reg <= 1'b0;
      case (state_reg)
        P_IDLE:
        begin
          // Every start begins with a fresh double read
          if (start_req)
          begin
            state_reg <= P_RD1;
            rd_go_reg <= 1'b1;
          end
          else if (rstcmd_req)
          begin
            state_reg <= P_RSTCMD;
            wr_go_reg <= 1'b1;
          end
        end
        P_RD1, P_RD3:
        begin
          if (cyc_done)
          begin
            samp1_reg <= cyc_rdata;
            state_reg <= (state_reg == P_RD1) ? P_RD2 : P_RD4;
            rd_go_reg <= 1'b1;
          end
        end
        P_RD2, P_RD4:
        begin
          if (cyc_done)
          begin
            samp2_reg <= cyc_rdata;
            state_reg <= (state_reg == P_RD2) ? P_EVAL : P_EVAL2;
          end
        end
        P_EVAL:
        begin
          // Mode from the first toggle bit, sector from the erase toggle bit
          erase_act_reg <= samp1_reg[TOG1_POS] ^ samp2_reg[TOG1_POS];
          sect_sel_reg <= samp1_reg[TOG2_POS] ^ samp2_reg[TOG2_POS];
          rd_go_reg <= 1'b1;
          if (!toggled)
            state_reg <= P_ARRAY;
          else if (samp2_reg[TMO_POS])
            state_reg <= P_RD3;
          else if (cont_reg)
            state_reg <= P_RD1;
          else
          begin
            rd_go_reg <= 1'b0;
            outcome_reg <= OUT_LEFT;
            ev_left_reg <= 1'b1;
            state_reg <= P_IDLE;
          end
        end
        P_EVAL2:
        begin
          if (!toggled)
          begin
            state_reg <= P_ARRAY;
            rd_go_reg <= 1'b1;
          end
          else
          begin
            // Toggling past the error bit is a failed operation
            state_reg <= P_RSTCMD;
            wr_go_reg <= 1'b1;
            fail_pend_reg <= 1'b1;
          end
        end
        P_ARRAY:
        begin
          if (cyc_done)
          begin
            array_reg <= cyc_rdata;
            outcome_reg <= OUT_DONE;
            ev_done_reg <= 1'b1;
            state_reg <= P_IDLE;
          end
        end
        P_RSTCMD:
        begin
          if (cyc_done)
          begin
            fail_pend_reg <= 1'b0;
            if (fail_pend_reg)
            begin
              outcome_reg <= OUT_FAIL;
              ev_fail_reg <= 1'b1;
            end
            state_reg <= P_IDLE;
          end
        end
        default:
          state_reg <= P_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_clr = (reg_wr_in && (reg_addr_in == REG_IRQ_STAT)) ?
                   reg_wdata_in[IRQ_W-1:0] : '0;
  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      // A new event beats a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {ev_left_reg, ev_fail_reg, ev_done_reg};
      if (reg_wr_in && (reg_addr_in == REG_IRQ_MASK))
        irq_mask_reg <= reg_wdata_in[IRQ_W-1:0];
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (reg_addr_in == REG_CTRL)
      rd_mux[CTRL_CONT:CTRL_SEL2] = {cont_reg, sel2_reg};
    else if (reg_addr_in == REG_ADDR)
      rd_mux[AW-1:0] = addr_reg;
    else if (reg_addr_in == REG_STATUS)
    begin
      rd_mux[ST_BUSY] = (state_reg != P_IDLE);
      rd_mux[ST_RDY] = ready_sync;
      rd_mux[ST_OUT_LO +: 2] = outcome_reg;
      rd_mux[ST_ERASE_ACT] = erase_act_reg;
      rd_mux[ST_SECT_SEL] = sect_sel_reg;
      rd_mux[ST_ETMR] = samp2_reg[ETMR_POS];
      rd_mux[ST_POLL] = samp2_reg[POLL_POS];
      rd_mux[ST_TMO] = samp2_reg[TMO_POS];
    end
    else if (reg_addr_in == REG_RESULT)
      rd_mux[7:0] = array_reg;
    else if (reg_addr_in == REG_IRQ_STAT)
      rd_mux[IRQ_W-1:0] = irq_stat_reg;
    else if (reg_addr_in == REG_IRQ_MASK)
      rd_mux[IRQ_W-1:0] = irq_mask_reg;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rstn_in || !reg_rd_in)
      reg_rdata_out <= '0;
    else
      reg_rdata_out <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_start_double: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_IDLE && start_req) |=> (state_reg == P_RD1 && rd_go_reg))
    else $error("start did not begin a double read");
  a_second_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_RD1 && cyc_done) |=> (state_reg == P_RD2 && samp1_reg == $past(cyc_rdata)))
    else $error("first sample not followed by second read");
  a_steady_done: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_EVAL && !toggled) |=> (state_reg == P_ARRAY) ##1 !ev_fail_reg)
    else $error("steady toggle did not lead to array read");
  a_error_recheck: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_EVAL && toggled && samp2_reg[TMO_POS]) |=> state_reg == P_RD3)
    else $error("error bit did not trigger recheck");
  a_fail_reset: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_EVAL2 && toggled) |=> wr_go_reg ##[1:40] ev_fail_reg)
    else $error("failure did not send reset command");
  a_leave_restart: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_EVAL && toggled && !samp2_reg[TMO_POS]) |=>
    (cont_reg ? state_reg == P_RD1 : (state_reg == P_IDLE && ev_left_reg)))
    else $error("polling did not restart or leave");
  a_mode_flags: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state_reg == P_EVAL) |=> (erase_act_reg == ($past(samp1_reg[TOG1_POS]) ^
    $past(samp2_reg[TOG1_POS])) && sect_sel_reg == ($past(samp1_reg[TOG2_POS]) ^
    $past(samp2_reg[TOG2_POS]))))
    else $error("mode flags wrong");
  a_irq_level: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (|(irq_stat_reg & irq_mask_reg)) |=> irq_out)
    else $error("interrupt not raised");
  a_read_once: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data held past its cycle");

endmodule

/* flash_status_model.sv */
// Behavioural parallel flash that reports embedded-operation status on reads.
// Assumes the bench loads each operation with go_in and pulls the ready pin up.
`timescale 1ns/100ps
module flash_status_model
#(
  parameter logic [3:0] SEL_SECT = 4'h3,
  parameter logic [7:0] ARRAY_BYTE = 8'h5a,
  parameter logic [7:0] SUSPEND_CMD = 8'hb0,
  parameter logic [7:0] RESET_CMD = 8'hf0
)
(
  input wire logic [19:0] addr_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  input wire logic [7:0] wdata_in,
  input wire logic go_in,
  input wire logic [1:0] mode_in,
  input wire logic [7:0] left_in,
  input wire logic fail_in,
  output logic [7:0] dq_out,
  output logic busy_low_out
);
  // Mode 0 array, 1 program, 2 erase, 3 erase suspended
  logic [1:0] mode_r = 2'h0;
  logic [7:0] left_r = 8'h00;
  logic fail_r = 1'b0;
  logic tog1_r = 1'b0;
  logic tog2_r = 1'b0;
  logic [7:0] last_r = ARRAY_BYTE;
  logic rd_act;
  logic sel;
  assign rd_act = !ce_n_in && !oe_n_in;
  // Released bus shows the inverse so a stale byte cannot pass for a sample
  assign dq_out = rd_act ? last_r : ~last_r;
  assign busy_low_out = mode_r == 2'h1 || mode_r == 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge go_in)
  begin
    mode_r = mode_in;
    left_r = left_in;
    fail_r = fail_in;
  end

  // Read strobes advance the status while busy or at a suspended sector; completion lands on a read
  always @(posedge rd_act)
  begin
    // Decoded here so an address launched with the strobe is the one used
    sel = addr_in[19:16] == SEL_SECT;
    if (busy_low_out && left_r == 8'h00)
    begin
      mode_r = 2'h0;
      fail_r = 1'b0;
    end
    else if (busy_low_out)
    begin
      left_r = left_r - 8'h01;
      tog1_r = ~tog1_r;
      tog2_r = (mode_r == 2'h2 && sel) ? ~tog2_r : tog2_r;
    end
    else if (mode_r == 2'h3 && sel)
      tog2_r = ~tog2_r;
    case (mode_r)
      2'h1: last_r = {~ARRAY_BYTE[7], tog1_r, fail_r, 2'b00, tog2_r, 2'b00};
      2'h2: last_r = {1'b0, tog1_r, fail_r, 2'b01, tog2_r, 2'b00};
      2'h3: last_r = sel ? {1'b1, tog1_r, 3'b000, tog2_r, 2'b00} : ARRAY_BYTE;
      default: last_r = ARRAY_BYTE;
    endcase
  end

  always @(posedge we_n_in)
  begin
    if (mode_r == 2'h2 && !fail_r && wdata_in == SUSPEND_CMD)
      mode_r = 2'h3;
    else if (!(mode_r == 2'h2 && !fail_r) && wdata_in == RESET_CMD)
      mode_r = 2'h0;
  end
endmodule

/* flash_poll_host_tb_top.sv */
// Bench for the flash status-polling host: a table of polling cases, then
// interrupt, ignored-command and mid-check reset cases.
// Assumes flash_status_model stands on the flash pins with a pull-up on ready.
`timescale 1ns/100ps
module flash_poll_host_tb_top;
  import flash_poll_pkg::*;
  typedef struct {
    logic [1:0] mode;
    logic sec;
    logic [7:0] left;
    logic fail;
    logic [2:0] ctl;
    logic [8:0] st;
    logic [8:0] msk;
    logic rchk;
  } row_t;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic irq_out;
  logic [19:0] flash_addr_out;
  logic flash_ce_n_out;
  logic flash_oe_n_out;
  logic flash_we_n_out;
  logic [7:0] dq_out;
  logic dq_oe_out;
  logic [7:0] model_dq;
  logic busy_low;
  logic m_go = 1'b0;
  logic [1:0] m_mode = 2'h0;
  logic [7:0] m_left = 8'h00;
  logic m_fail = 1'b0;
  logic [2:0] mask_v = 3'h0;
  logic [31:0] s;
  int error_cnt = 0;
  int n_checks = 0;
  // Ctl is {continuous, erase toggle select, start}; st is the expected status
  row_t rows[8] = '{
    '{2'h1, 1'b0, 8'h00, 1'b0, 3'h1, 9'h046, 9'h1ff, 1'b1},
    '{2'h1, 1'b0, 8'hff, 1'b0, 3'h1, 9'h09c, 9'h1ff, 1'b0},
    '{2'h2, 1'b1, 8'hff, 1'b0, 3'h3, 9'h07c, 9'h1ff, 1'b0},
    '{2'h3, 1'b1, 8'h00, 1'b0, 3'h1, 9'h0a6, 9'h1ff, 1'b0},
    '{2'h3, 1'b0, 8'h00, 1'b0, 3'h3, 9'h046, 9'h1ff, 1'b1},
    '{2'h2, 1'b1, 8'hff, 1'b1, 3'h1, 9'h17a, 9'h1ff, 1'b0},
    '{2'h2, 1'b1, 8'h02, 1'b1, 3'h1, 9'h076, 9'h1ff, 1'b1},
    '{2'h1, 1'b0, 8'h04, 1'b0, 3'h5, 9'h046, 9'h1cf, 1'b1}
  };

  // Open-drain ready line with pull-up; host drive wins on the data bus
  wire [7:0] dq_in = dq_oe_out ? dq_out : model_dq;
  wire ready_busy_n_in = busy_low ? 1'b0 : 1'b1;

  flash_poll_host #(.AW(20)) dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
    .dq_in(dq_in), .ready_busy_n_in(ready_busy_n_in), .flash_addr_out(flash_addr_out),
    .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
    .flash_we_n_out(flash_we_n_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out));

  flash_status_model flash (.addr_in(flash_addr_out), .ce_n_in(flash_ce_n_out),
    .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .wdata_in(dq_out),
    .go_in(m_go), .mode_in(m_mode), .left_in(m_left), .fail_in(m_fail),
    .dq_out(model_dq), .busy_low_out(busy_low));

  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic load_op(input logic [1:0] mode, input logic [7:0] left, input logic fail);
    @(posedge clk_sys_in);
    m_mode <= mode;
    m_left <= left;
    m_fail <= fail;
    // Fields settle a cycle before the load strobe rises
    @(posedge clk_sys_in);
    m_go <= 1'b1;
    @(posedge clk_sys_in);
    m_go <= 1'b0;
  endtask

  task automatic run_row(input row_t r);
    logic [31:0] d;
    logic [2:0] ev;
    load_op(r.mode, r.left, r.fail);
    reg_wr(REG_ADDR, r.sec ? 32'h30000 : 32'h50000);
    reg_wr(REG_CTRL, {29'h0, r.ctl});
    d = 32'h1;
    for (int i = 0; i < 400 && d[ST_BUSY] !== 1'b0; i++)
      reg_rd(REG_STATUS, d);
    if (d[ST_BUSY] !== 1'b0)
    begin
      error_cnt++;
      $display("wrong value busy wait expected 0 seen %h", d);
      summarize();
    end
    repeat (8) @(posedge clk_sys_in);
    reg_rd(REG_STATUS, d);
    check("status", d & {23'h0, r.msk}, {23'h0, r.st});
    if (r.rchk)
    begin
      reg_rd(REG_RESULT, d);
      check("result", d, 32'h5a);
    end
    ev = 3'h1 << (r.st[3:2] - 2'h1);
    reg_rd(REG_IRQ_STAT, d);
    check("irq stat", d, {29'h0, ev});
    check("irq on", {31'h0, irq_out}, {31'h0, |(ev & mask_v)});
    reg_wr(REG_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk_sys_in);
    check("irq off", {31'h0, irq_out}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    foreach (rows[i])
      run_row(rows[i]);
    // Interrupt raised when unmasked, held back when masked
    mask_v = 3'h1;
    reg_wr(REG_IRQ_MASK, {29'h0, mask_v});
    run_row(rows[0]);
    mask_v = 3'h2;
    reg_wr(REG_IRQ_MASK, {29'h0, mask_v});
    run_row(rows[1]);
    // A reset byte sent while erasing has begun must be ignored
    load_op(2'h2, 8'hff, 1'b0);
    reg_wr(REG_CTRL, 32'h8);
    repeat (40) @(posedge clk_sys_in);
    reg_rd(REG_STATUS, s);
    check("ready pin", {31'h0, s[ST_RDY]}, 32'h0);
    reg_rd(REG_CTRL, s);
    check("ctrl", s, 32'h0);
    // Reset in mid-check drops the flash strobes and clears the registers
    reg_wr(REG_ADDR, 32'h30000);
    reg_wr(REG_CTRL, 32'h1);
    repeat (10) @(posedge clk_sys_in);
    check("addr", {12'h0, flash_addr_out}, 32'h30000);
    rstn_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 check("pins", {28'h0, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, dq_oe_out}, 32'he);
    @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    reg_rd(REG_IRQ_MASK, s);
    check("mask", s, 32'h0);
    reg_rd(8'h20, s);
    check("unmapped", s, 32'h0);
    reg_rd(REG_STATUS, s);
    check("status", s & 32'hf, 32'h0);
    summarize();
  end
endmodule
